// >>> src/tecp_timer.sv
// 16-bit timer channel: external event count and trigger PWM modes.
// Assumes event and trigger inputs are one-cycle valid-edge pulses.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tecp_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_event_edge,
  input wire logic ext_trig_edge,
  output logic period_match_irq,
  output logic [2:0] channel_match_irq,
  output logic square_wave_output,
  output logic [2:0] pwm_output_k,
  output logic [3:0] timer_out_en
);

  tecp_pkg::tecp_ctl_t ctl_r;
  tecp_pkg::tecp_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] ccr_r [4];
  logic [15:0] buf_r [4];
  logic [15:0] buf_nxt [4];
  logic [7:0] psc_r;
  logic ovf_r, arm_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic irq0_r, sq_r;
  logic [2:0] irqk_r, irqk_nxt, pwm_r, pwm_nxt, buf_zero;
  logic [3:0] en_r;
  logic per_clr, start, trig_run, ovf_set;

  // Bus decode
  wire logic acc = psel & penable;
  wire logic hit_ctl0 = paddr == tecp_pkg::OFS_CTL0;
  wire logic hit_ctl1 = paddr == tecp_pkg::OFS_CTL1;
  wire logic hit_opt0 = paddr == tecp_pkg::OFS_OPT0;
  wire logic hit_cnt = paddr == tecp_pkg::OFS_CNT;
  logic [3:0] hit_ccr;
  assign hit_ccr[0] = paddr == tecp_pkg::OFS_CCR0;
  assign hit_ccr[1] = paddr == tecp_pkg::OFS_CCR1;
  assign hit_ccr[2] = paddr == tecp_pkg::OFS_CCR2;
  assign hit_ccr[3] = paddr == tecp_pkg::OFS_CCR3;
  wire logic map_hit = hit_ctl0 | hit_ctl1 | hit_opt0 | hit_cnt | (|hit_ccr);
  wire logic wr_en = acc & pready_r & pwrite & map_hit;
  wire logic [3:0] wr_ccr = hit_ccr & {4{wr_en}};

  // Mode and trigger decode
  wire logic evt = ctl_r.md == tecp_pkg::MODE_EVT;
  wire logic trg = ctl_r.md == tecp_pkg::MODE_TRG;
  wire logic est_wr = wr_en & hit_ctl1 & pwdata[tecp_pkg::EST_BIT];
  wire logic trig = trg & (ext_trig_edge | est_wr);

  // Count clock: divider tick or external edge
  wire logic [7:0] psc_mask = ~(tecp_pkg::PSC_ONES << ctl_r.cks);
  wire logic psc_tick = (psc_r & psc_mask) == psc_mask;
  wire logic cnt_tick = (evt | ctl_r.eee) ? ext_event_edge : psc_tick;
  wire logic running = st_r == tecp_pkg::ST_RUN;
  wire logic step = running & ctl_r.ce & ~trig & cnt_tick;
  wire logic reload = per_clr & trg & arm_r;

  // Counter sequencing
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    per_clr = 1'b0;
    start = 1'b0;
    trig_run = 1'b0;
    ovf_set = 1'b0;
    case (st_r)
      tecp_pkg::ST_STOP: begin
        cnt_nxt = tecp_pkg::CNT_IDLE;
        if (ctl_r.ce && evt) begin
          start = 1'b1;
          st_nxt = tecp_pkg::ST_RUN;
          cnt_nxt = tecp_pkg::CNT_ZERO;
        end else if (ctl_r.ce && trg) begin
          start = 1'b1;
          st_nxt = tecp_pkg::ST_WAIT;
        end
      end
      tecp_pkg::ST_WAIT: begin
        if (!ctl_r.ce) begin
          st_nxt = tecp_pkg::ST_STOP;
        end else if (trig) begin
          st_nxt = tecp_pkg::ST_RUN;
          cnt_nxt = tecp_pkg::CNT_ZERO;
          trig_run = 1'b1;
        end
      end
      tecp_pkg::ST_RUN: begin
        if (!ctl_r.ce) begin
          st_nxt = tecp_pkg::ST_STOP;
          cnt_nxt = tecp_pkg::CNT_IDLE;
        end else if (trig) begin
          cnt_nxt = tecp_pkg::CNT_ZERO;
          trig_run = 1'b1;
        end else if (cnt_tick) begin
          if (cnt_r == buf_r[0]) begin
            cnt_nxt = tecp_pkg::CNT_ZERO;
            per_clr = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
            ovf_set = cnt_r == tecp_pkg::CNT_IDLE;
          end
        end
      end
      default: begin
        st_nxt = tecp_pkg::ST_STOP;
        cnt_nxt = tecp_pkg::CNT_IDLE;
      end
    endcase
  end

  // Compare buffers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_buf
      wire logic evt_wr = evt & running & wr_ccr[gi];
      assign buf_nxt[gi] = evt_wr ? pwdata[15:0] :
                           (start | reload) ? ccr_r[gi] : buf_r[gi];
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          ccr_r[gi] <= tecp_pkg::CCR_RST;
          buf_r[gi] <= tecp_pkg::CCR_RST;
        end else begin
          if (wr_ccr[gi]) begin
            ccr_r[gi] <= pwdata[15:0];
          end
          buf_r[gi] <= buf_nxt[gi];
        end
      end
    end
  endgenerate

  // Channel matches and PWM levels
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      wire logic eq_nxt = cnt_nxt == buf_nxt[gi+1];
      wire logic evt_hit = evt & step & (cnt_r == buf_r[gi+1]);
      wire logic trg_hit = trg & step & eq_nxt;
      wire logic pwm_lo = (step | trig_run) & eq_nxt;
      wire logic pwm_hi = trig_run | per_clr;
      assign buf_zero[gi] = buf_r[gi+1] == tecp_pkg::CNT_ZERO;
      assign irqk_nxt[gi] = evt_hit | trg_hit;
      assign pwm_nxt[gi] = trg & (st_nxt == tecp_pkg::ST_RUN) &
                           (pwm_hi | pwm_r[gi]) & ~pwm_lo;
    end
  endgenerate

  wire logic sq_flip = (trig_run & running) | per_clr;
  wire logic sq_nxt = trg & (st_nxt != tecp_pkg::ST_STOP) & (sq_r ^ sq_flip);
  wire logic [3:0] en_nxt = {4{trg & (st_nxt != tecp_pkg::ST_STOP)}};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= tecp_pkg::ST_STOP;
      cnt_r <= tecp_pkg::CNT_IDLE;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      psc_r <= 8'h00;
    end else begin
      psc_r <= running ? psc_r + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq0_r <= 1'b0;
      irqk_r <= 3'h0;
      pwm_r <= 3'h0;
      sq_r <= 1'b0;
      en_r <= 4'h0;
    end else begin
      irq0_r <= per_clr;
      irqk_r <= irqk_nxt;
      pwm_r <= pwm_nxt;
      sq_r <= sq_nxt;
      en_r <= en_nxt;
    end
  end

  // Control, overflow and reload arming; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctl_r <= tecp_pkg::CTL_RST;
      ovf_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      if (wr_en && hit_ctl0) begin
        ctl_r.ce <= pwdata[tecp_pkg::CE_BIT];
        ctl_r.cks <= pwdata[tecp_pkg::CKS_LSB +: 3];
      end
      if (wr_en && hit_ctl1) begin
        ctl_r.eee <= pwdata[tecp_pkg::EEE_BIT];
        ctl_r.md <= pwdata[tecp_pkg::MD_LSB +: 3];
      end
      if (ovf_set) begin
        ovf_r <= 1'b1;
      end else if (wr_en && hit_opt0 && !pwdata[tecp_pkg::OVF_BIT]) begin
        ovf_r <= 1'b0;
      end
      if (trg && wr_ccr[1]) begin
        arm_r <= 1'b1;
      end else if (reload || !trg) begin
        arm_r <= 1'b0;
      end
    end
  end

  // Read data
  wire logic [15:0] ccr_rd = hit_ccr[0] ? ccr_r[0] : hit_ccr[1] ? ccr_r[1] :
                             hit_ccr[2] ? ccr_r[2] : ccr_r[3];
  wire logic [31:0] rd_data =
    hit_ctl0 ? {24'h00_0000, ctl_r.ce, 4'h0, ctl_r.cks} :
    hit_ctl1 ? {24'h00_0000, 2'h0, ctl_r.eee, 2'h0, ctl_r.md} :
    hit_opt0 ? {31'h0000_0000, ovf_r} :
    hit_cnt ? {16'h0000, cnt_r} :
    (|hit_ccr) ? {16'h0000, ccr_rd} : tecp_pkg::RD_NONE;

  // APB: one wait state, answer in the second access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= tecp_pkg::RD_NONE;
    end else begin
      pready_r <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~map_hit;
      prdata_r <= (acc & ~pready_r & ~pwrite) ? rd_data : tecp_pkg::RD_NONE;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign period_match_irq = irq0_r;
  assign channel_match_irq = irqk_r;
  assign square_wave_output = sq_r;
  assign pwm_output_k = pwm_r;
  assign timer_out_en = en_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  wire logic rd_cnt = acc & ~pready_r & ~pwrite & hit_cnt;

  property p_cnt_read;
    rd_cnt |=> prdata[15:0] == $past(cnt_r) && pready;
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read wrong");

  property p_evt_clear;
    evt && step && cnt_r == buf_r[0] |=> cnt_r == 16'h0000 && period_match_irq;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("event period missed");

  property p_evt_no_out;
    $past(evt) && evt |-> timer_out_en == 4'h0;
  endproperty
  a_evt_no_out: assert property (p_evt_no_out) else $error("event mode drives out");

  property p_wrap_ffff;
    evt && step && cnt_r == 16'hFFFF && buf_r[0] == 16'hFFFF
      |=> cnt_r == 16'h0000 && period_match_irq && ovf_r == $past(ovf_r);
  endproperty
  a_wrap_ffff: assert property (p_wrap_ffff) else $error("FFFF wrap wrong");

  property p_evt_wr_buf;
    evt && running && wr_ccr[0] |=> buf_r[0] == $past(pwdata[15:0]);
  endproperty
  a_evt_wr_buf: assert property (p_evt_wr_buf) else $error("buffer not loaded");

  property p_first_trig;
    st_r == tecp_pkg::ST_WAIT && ctl_r.ce && trig
      |=> cnt_r == 16'h0000 && st_r == tecp_pkg::ST_RUN ##1 cnt_r != 16'hFFFF;
  endproperty
  a_first_trig: assert property (p_first_trig) else $error("start from wait wrong");

  property p_run_trig;
    running && ctl_r.ce && trig
      |=> cnt_r == 16'h0000 && square_wave_output != $past(square_wave_output);
  endproperty
  a_run_trig: assert property (p_run_trig) else $error("restart wrong");

  property p_trig_high;
    ctl_r.ce && trig && st_r != tecp_pkg::ST_STOP |=> &(pwm_output_k | $past(buf_zero));
  endproperty
  a_trig_high: assert property (p_trig_high) else $error("PWM not high");

  property p_trg_period;
    trg && step && cnt_r == buf_r[0] |=> period_match_irq && cnt_r == 16'h0000;
  endproperty
  a_trg_period: assert property (p_trg_period) else $error("period irq late");

  property p_trg_ch;
    trg && channel_match_irq[0] |-> cnt_r == buf_r[1] && !pwm_output_k[0];
  endproperty
  a_trg_ch: assert property (p_trg_ch) else $error("channel irq off");

  property p_reload;
    reload |=> buf_r[0] == $past(ccr_r[0]) && arm_r == $past(wr_ccr[1]);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missing");

  property p_no_arm;
    trg && running && !arm_r |=> $stable(buf_r[0]);
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("unarmed reload");

  property p_stop;
    running && !ctl_r.ce |=> cnt_r == 16'hFFFF && st_r == tecp_pkg::ST_STOP ##1 cnt_r == 16'hFFFF;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not parked");

  c_evt_irq: cover property (evt && period_match_irq);
  c_trg_run: cover property (trg && running && trig);
  c_pwm_fall: cover property (trg && $fell(pwm_output_k[0]));
  c_ovf: cover property ($rose(ovf_r));

endmodule
`default_nettype wire

// >>> src/tecp_pkg.sv
// Constants, types and register map of the timer channel.
// Assumes an APB master with 32-bit data and 6-bit byte addresses.
//
// Summary of operation
// - Mode field 001 events, 010 trigger PWM
// - Count register reads the live counter
// - Events: clear and interrupt after D0+1 edges
// - Events: channel buffers load, matches still interrupt
// - Event mode drives no timer output
// - Period FFFFH wraps with interrupt, no overflow
// - Events: period write reaches buffer at once
// - Channel below period interrupts once per cycle
// - Channel above period never interrupts
// - Enable waits; trigger starts count and PWM
// - First trigger steps FFFFH to 0000H
// - Running trigger clears, restarts, inverts output 0
// - Every trigger drives PWM outputs high, except channels whose compare buffer is zero
// - Output 0 toggles once per PWM period
// - Width is channel value, period is D0+1
// - Period interrupt and clear after equal step
// - Trigger mode: channel interrupt in the equal cycle
// - Armed trigger-mode period clear copies compares into buffers
// - Pin edge or software bit triggers
// - Clock select ignored with external clock
// - Trigger mode reload armed by channel-1 write
package tecp_pkg;

  localparam int AW = 6;
  localparam logic [AW-1:0] OFS_CTL0 = 6'h00;
  localparam logic [AW-1:0] OFS_CTL1 = 6'h04;
  localparam logic [AW-1:0] OFS_OPT0 = 6'h08;
  localparam logic [AW-1:0] OFS_CNT = 6'h0C;
  localparam logic [AW-1:0] OFS_CCR0 = 6'h10;
  localparam logic [AW-1:0] OFS_CCR1 = 6'h14;
  localparam logic [AW-1:0] OFS_CCR2 = 6'h18;
  localparam logic [AW-1:0] OFS_CCR3 = 6'h1C;

  localparam int CE_BIT = 7;
  localparam int EST_BIT = 6;
  localparam int EEE_BIT = 5;
  localparam int OVF_BIT = 0;
  localparam int CKS_LSB = 0;
  localparam int MD_LSB = 0;

  localparam logic [2:0] MODE_EVT = 3'h1;
  localparam logic [2:0] MODE_TRG = 3'h2;
  localparam logic [15:0] CNT_IDLE = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CCR_RST = 16'h0000;
  localparam logic [7:0] PSC_ONES = 8'hFF;
  localparam logic [31:0] RD_NONE = 32'h0000_0000;

  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN} tecp_state_t;

  typedef struct packed {
    logic ce;
    logic [2:0] cks;
    logic eee;
    logic [2:0] md;
  } tecp_ctl_t;

  localparam tecp_ctl_t CTL_RST = '{ce: 1'b0, cks: 3'h0, eee: 1'b0, md: 3'h0};

endpackage

// >>> tb/tecp_pins.sv
// Partner model: external event and trigger valid-edge pulses.
// Assumes edge detection sits outside the timer; one pulse per edge.
`timescale 1ns/1ns
`default_nettype none
module tecp_pins (
  input wire logic sys_clk,
  output logic ext_event_edge,
  output logic ext_trig_edge
);
  initial begin
    ext_event_edge = 1'b0;
    ext_trig_edge = 1'b0;
  end
  // Event pulses with a chosen idle gap
  task automatic events(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk) ext_event_edge <= 1'b1;
      @(posedge sys_clk) ext_event_edge <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
  task automatic trig();
    @(posedge sys_clk) ext_trig_edge <= 1'b1;
    @(posedge sys_clk) ext_trig_edge <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tecp_timer_tb.sv
// Testbench: APB master, pulse partner and pulse counters.
// Assumes one wait state APB slave and count clock divide by one, or by two in the external clock test.
`timescale 1ns/1ns
`default_nettype none
module tecp_timer_tb;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, ev, tr, per_irq, sq;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] ch_irq, pwm;
  logic [3:0] oen;
  logic sq_q = 1'b0;
  int fails = 0, checks_done = 0, n_per = 0, n_ch1 = 0, n_ch2 = 0, n_ch3 = 0, n_pwm = 0, n_sq = 0;
  tecp_timer tecp_timer_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_event_edge(ev), .ext_trig_edge(tr), .period_match_irq(per_irq),
    .channel_match_irq(ch_irq), .square_wave_output(sq), .pwm_output_k(pwm), .timer_out_en(oen));
  tecp_pins tecp_pins_i (.sys_clk(sys_clk), .ext_event_edge(ev), .ext_trig_edge(tr));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Running tallies of pulses and levels
  always @(posedge sys_clk) begin
    n_per <= n_per + int'(per_irq === 1'b1);
    n_ch1 <= n_ch1 + int'(ch_irq[0] === 1'b1);
    n_ch2 <= n_ch2 + int'(ch_irq[1] === 1'b1);
    n_ch3 <= n_ch3 + int'(ch_irq[2] === 1'b1);
    n_pwm <= n_pwm + int'(pwm[0] === 1'b1);
    n_sq <= n_sq + int'(sq !== sq_q);
    sq_q <= sq;
  end
  task automatic summarize();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      if (per_irq === 1'b1) break;
    end
    chk("period irq seen", per_irq, 1);
  endtask
  // Window of 50 cycles aligned to a period clear
  task automatic measure(input int ep, input int ew);
    int p, c, w, s;
    wait_irq();
    p = n_per;
    c = n_ch1;
    w = n_pwm;
    s = n_sq;
    repeat (50) @(posedge sys_clk);
    chk("period irqs", n_per - p, ep);
    chk("channel irqs", n_ch1 - c, ep);
    chk("square toggles", n_sq - s, ep);
    chk("pwm high cycles", n_pwm - w, ew);
  endtask
  task automatic test_regs();
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("count at reset", rd, 32'h0000_FFFF);
    apb(1, tecp_pkg::OFS_CNT, 32'h0000_1234);
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("count read only", rd, 32'h0000_FFFF);
    apb(0, tecp_pkg::OFS_CCR0, 0);
    chk("compare reset", rd, 32'h0000_0000);
    apb(0, 6'h20, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    $display("test regs done");
  endtask
  task automatic test_events();
    int p, c1, c2, c3;
    apb(1, tecp_pkg::OFS_CTL1, 32'h0000_0001);
    apb(1, tecp_pkg::OFS_CCR0, 32'h0000_0002);
    apb(1, tecp_pkg::OFS_CCR1, 32'h0000_0001);
    apb(1, tecp_pkg::OFS_CCR2, 32'h0000_0005);
    apb(1, tecp_pkg::OFS_CTL0, 32'h0000_0080);
    p = n_per;
    c1 = n_ch1;
    c2 = n_ch2;
    c3 = n_ch3;
    tecp_pins_i.events(6, 1);
    repeat (3) @(posedge sys_clk);
    chk("event period irqs", n_per - p, 2);
    chk("event ch1 irqs", n_ch1 - c1, 2);
    chk("event ch2 irqs", n_ch2 - c2, 0);
    chk("event ch3 irqs", n_ch3 - c3, 2);
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("event count cleared", rd, 0);
    tecp_pins_i.events(1, 0);
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("event count one", rd, 1);
    apb(1, tecp_pkg::OFS_CCR0, 32'h0000_0003);
    tecp_pins_i.events(2, 1);
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("raised period count", rd, 3);
    chk("event outputs", {sq, pwm, oen}, 0);
    apb(1, tecp_pkg::OFS_CTL0, 0);
    $display("test events done");
  endtask
  task automatic test_trigger();
    logic s;
    apb(1, tecp_pkg::OFS_CTL1, 32'h0000_0002);
    apb(1, tecp_pkg::OFS_CCR0, 32'h0000_0004);
    apb(1, tecp_pkg::OFS_CCR2, 32'h0000_0003);
    apb(1, tecp_pkg::OFS_CCR3, 32'h0000_0001);
    apb(1, tecp_pkg::OFS_CCR1, 32'h0000_0002);
    apb(1, tecp_pkg::OFS_CTL0, 32'h0000_0080);
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("waiting count", rd, 32'h0000_FFFF);
    chk("waiting enables", oen, 4'hF);
    chk("waiting pwm", pwm, 0);
    apb(1, tecp_pkg::OFS_CTL1, 32'h0000_0042);
    measure(10, 20);
    apb(1, tecp_pkg::OFS_CCR0, 32'h0000_0009);
    measure(10, 20);
    apb(1, tecp_pkg::OFS_CCR1, 32'h0000_0002);
    wait_irq();
    measure(5, 10);
    wait_irq();
    s = sq;
    tecp_pins_i.trig();
    @(posedge sys_clk);
    chk("square inverted", sq, !s);
    chk("pwm all high", pwm, 3'b111);
    apb(1, tecp_pkg::OFS_CTL0, 0);
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("parked count", rd, 32'h0000_FFFF);
    chk("parked enables", oen, 0);
    $display("test trigger done");
  endtask
  // External event clock in trigger mode, then divide by two
  task automatic test_ext_clock();
    apb(1, tecp_pkg::OFS_CTL1, 32'h0000_0022);
    apb(1, tecp_pkg::OFS_CTL0, 32'h0000_0081);
    apb(1, tecp_pkg::OFS_CTL1, 32'h0000_0062);
    tecp_pins_i.events(3, 1);
    apb(0, tecp_pkg::OFS_CNT, 0);
    chk("external clock count", rd, 3);
    chk("external clock outputs", oen, 4'hF);
    apb(1, tecp_pkg::OFS_CTL1, 32'h0000_0002);
    measure(3, 12);
    apb(1, tecp_pkg::OFS_CTL0, 0);
    $display("test external clock done");
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_regs();
    test_events();
    test_trigger();
    test_ext_clock();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
